// file: rtl/bsxd_decoder.sv
// Bit-test skip and extended instruction decoder and sequencer
//
// Functional notes
// (RULE1) Taken tests and jumps cost two cycles
// (RULE2) Lone second word executes as no-op
// (RULE3) Port read-modify-write uses pin values
// (RULE4) Timer zero writes clear its prescaler
// (RULE5) Pattern 1011 skips when bit clear
// (RULE6) Pattern 1010 skips when bit set
// (RULE7) Taken skip discards prefetched instruction
// (RULE8) Skipping two-word instruction costs three cycles
// (RULE9) Bank bit zero picks access bank
// (RULE10) Bank bit one uses bank select
// (RULE11) Extended access below 96 uses indexing
// (RULE12) Eight extended opcodes, enabled by configuration
// (RULE13) Pointer add/sub literal, one cycle
// (RULE14) Pointer two variant returns, two cycles
// (RULE15) Call via working register, two cycles
// (RULE16) Stack moves to file or stack
// (RULE17) Push literal then decrement pointer two
// (RULE18) Extended enable held static
`include "bsxd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module bsxd_decoder (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic        extendedSetCfg,
    input  wire logic [15:0] instrWord,
    input  wire logic        instrValid,
    input  wire logic [7:0]  fileData,
    input  wire logic [7:0]  pinData,
    input  wire logic [3:0]  bankSelect,
    input  wire logic [7:0]  workingReg,
    input  wire logic [11:0] pointerTwo,
    input  wire logic        prescalerOnTimer,
    input  wire logic        rmwDestFile,
    output logic [11:0] fileAddr,
    output logic        useIndexed,
    output logic        operandFromPins,
    output logic        clearPrescaler,
    output logic        skipTaken,
    output logic        nopCycle,
    output logic        pointerWrite,
    output logic [1:0]  pointerSel,
    output logic [6:0]  pointerDelta,
    output logic        pointerDecrement,
    output logic        returnReq,
    output logic        callReq,
    output logic [7:0]  callLow,
    output logic        pushWrite,
    output logic [7:0]  pushData,
    output logic        moveReq,
    output logic        moveToStack,
    output logic [6:0]  moveSrcOffset,
    output logic [11:0] moveDst,
    output logic        illegalExt
);

    // ***************************************************
    // Decode
    // ***************************************************

    // Configuration caught at reset release and then frozen
    logic extEn;
    logic cfgLoaded;
    bsxd_pkg::bsxd_state_t state;
    logic        movePending;
    logic [6:0]  pendSrc;
    logic        pendToStack;

    function automatic logic [11:0] bsxd_bank_addr(input logic a, input logic [7:0] f,
                                                   input logic [3:0] bank_select_register);
        // Access bank splits low RAM from the upper special registers
        if (a)
            bsxd_bank_addr = {bank_select_register, f}; // RULE10
        else if (f >= 8'h60)
            bsxd_bank_addr = {4'hf, f}; // RULE9
        else
            bsxd_bank_addr = {4'h0, f}; // RULE9
    endfunction

    wire logic [3:0] opHi   = instrWord[15:12];
    wire logic [7:0] opByte = instrWord[15:8];
    wire logic [2:0] bitIdx = instrWord[11:9];
    wire logic       bankBit = instrWord[8];
    wire logic [7:0] fAddr  = instrWord[7:0];
    wire logic       isClr  = (opHi == `BSXD_OP_SKIP_CLR); // RULE5
    wire logic       isSet  = (opHi == `BSXD_OP_SKIP_SET); // RULE6
    wire logic       isTest = isClr | isSet;
    wire logic       idx    = extEn & ~bankBit & (fAddr <= `BSXD_INDEX_LIMIT); // RULE11
    wire logic [11:0] testAddr = idx ? (pointerTwo + {4'h0, fAddr}) : bsxd_bank_addr(bankBit, fAddr, bankSelect);
    wire logic       testBit = fileData[bitIdx];
    wire logic       takeSkip = (isClr & ~testBit) | (isSet & testBit); // RULE5 RULE6
    wire logic       isPAdd = extEn & (opByte == `BSXD_OP_PTR_ADD); // RULE12 RULE13
    wire logic       isPSub = extEn & (opByte == `BSXD_OP_PTR_SUB); // RULE13
    wire logic       isRet  = (isPAdd | isPSub) & (instrWord[7:6] == `BSXD_PTR_TWO); // RULE14
    wire logic       isCall = extEn & (instrWord == `BSXD_OP_CALL_WORKING_REGISTER); // RULE15
    wire logic       isPush = extEn & (opByte == `BSXD_OP_PUSH_LIT); // RULE17
    wire logic       isMove = extEn & (opByte == `BSXD_OP_STACK_MOVE); // RULE16
    wire logic       isTwoWord = (opHi == 4'hc) | (opByte == 8'hee) | (opByte == 8'heb) | (opHi == 4'he
                                 && instrWord[11:9] == 3'b110);
    wire logic       isSecond = (opHi == `BSXD_OP_SECOND_WORD);
    wire logic       extUnused = ~extEn & (opByte >= 8'he8) & (opByte <= 8'heb);
    wire logic       portHit = (testAddr >= `BSXD_PORT_BASE) && (testAddr <= `BSXD_PORT_LAST);
    wire logic       timerHit = (testAddr == `BSXD_TIMER_ZERO);
    wire logic       live = instrValid & (state == bsxd_pkg::BSXD_EXEC) & cfgLoaded;
    wire logic       byteOp = ~isTest & (opHi[3:2] != 2'b11) & (opHi != 4'h0);

    // Next state: flush one or two slots after taken skip or flow change
    bsxd_pkg::bsxd_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            bsxd_pkg::BSXD_EXEC: begin
                if (live && isTest && takeSkip)
                    next_state = bsxd_pkg::BSXD_FLUSH; // RULE7
                else if (live && (isRet || isCall))
                    next_state = bsxd_pkg::BSXD_FLUSH; // RULE1 RULE14 RULE15
            end
            bsxd_pkg::BSXD_FLUSH: begin
                if (instrValid && isTwoWord && skipTaken)
                    next_state = bsxd_pkg::BSXD_FLUSH2; // RULE8
                else if (instrValid)
                    next_state = bsxd_pkg::BSXD_EXEC;
            end
            bsxd_pkg::BSXD_FLUSH2: begin
                if (instrValid)
                    next_state = bsxd_pkg::BSXD_EXEC;
            end
            default: next_state = bsxd_pkg::BSXD_EXEC;
        endcase
    end

    // ***************************************************
    // State and outputs
    // ***************************************************

    // Sequencer and registered strobes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state            <= bsxd_pkg::BSXD_EXEC;
            extEn            <= 1'b0;
            cfgLoaded        <= 1'b0;
            movePending      <= 1'b0;
            pendSrc          <= 7'h00;
            pendToStack      <= 1'b0;
            fileAddr         <= 12'h000;
            useIndexed       <= 1'b0;
            operandFromPins  <= 1'b0;
            clearPrescaler   <= 1'b0;
            skipTaken        <= 1'b0;
            nopCycle         <= 1'b0;
            pointerWrite     <= 1'b0;
            pointerSel       <= 2'b00;
            pointerDelta     <= 7'h00;
            pointerDecrement <= 1'b0;
            returnReq        <= 1'b0;
            callReq          <= 1'b0;
            callLow          <= 8'h00;
            pushWrite        <= 1'b0;
            pushData         <= 8'h00;
            moveReq          <= 1'b0;
            moveToStack      <= 1'b0;
            moveSrcOffset    <= 7'h00;
            moveDst          <= 12'h000;
            illegalExt       <= 1'b0;
        end else if (clkEn) begin
            if (!cfgLoaded) begin
                extEn     <= extendedSetCfg; // RULE18
                cfgLoaded <= 1'b1;
            end
            state            <= next_state;
            fileAddr         <= testAddr;
            useIndexed       <= live & isTest & idx; // RULE11
            operandFromPins  <= live & portHit & (isTest | byteOp); // RULE3
            clearPrescaler   <= live & byteOp & timerHit & rmwDestFile & prescalerOnTimer; // RULE4
            skipTaken        <= live & isTest & takeSkip; // RULE7
            // Flushed slots and orphan second words run as no-ops
            nopCycle         <= (state != bsxd_pkg::BSXD_EXEC) | (live & isSecond & ~movePending); // RULE1 RULE2
            pointerWrite     <= live & (isPAdd | isPSub | isPush); // RULE13 RULE17
            pointerSel       <= isPush ? `BSXD_PTR_TWO : instrWord[7:6];
            pointerDelta     <= isPush ? 7'h01 : {1'b0, instrWord[5:0]};
            pointerDecrement <= isPSub | isPush; // RULE17
            returnReq        <= live & isRet; // RULE14
            callReq          <= live & isCall; // RULE15
            callLow          <= workingReg;
            pushWrite        <= live & isPush; // RULE17
            pushData         <= fAddr;
            illegalExt       <= live & extUnused;
            // Stack move collects its second word as operand
            moveReq          <= 1'b0;
            if (live && isMove) begin
                movePending <= 1'b1; // RULE16
                pendSrc     <= instrWord[6:0];
                pendToStack <= instrWord[7];
            end else if (live && movePending) begin
                movePending   <= 1'b0; // RULE2
                moveReq       <= isSecond;
                moveToStack   <= pendToStack; // RULE16
                moveSrcOffset <= pendSrc;
                moveDst       <= pendToStack ? {5'h00, instrWord[6:0]} : instrWord[11:0];
            end
        end
    end

    // ***************************************************
    // Checks
    // ***************************************************

    sequence s_skip_hit;
        live && isTest && takeSkip && clkEn;
    endsequence

    a_skip_flush_slot: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
        s_skip_hit |=> skipTaken && state == bsxd_pkg::BSXD_FLUSH)
        else $error("skip did not flush");
    a_skip_clear_sense: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
        (live && isClr && clkEn) |=> (skipTaken == ~$past(testBit)))
        else $error("clear test wrong");
    a_skip_set_sense: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
        (live && isSet && clkEn) |=> (skipTaken == $past(testBit)))
        else $error("set test wrong");
    a_flush_nop_cycle: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        (clkEn && state == bsxd_pkg::BSXD_FLUSH) |=> nopCycle)
        else $error("flush not a no-op");
    a_ret_two_cycle: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
        (live && isRet && clkEn) |=> returnReq && state == bsxd_pkg::BSXD_FLUSH)
        else $error("return variant not two cycles");
    a_push_ptr_dec: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
        (live && isPush && clkEn) |=> pushWrite && pointerDecrement && pointerSel == 2'b11)
        else $error("push wrong");
    a_call_working_register_low: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
        (live && isCall && clkEn) |=> callReq && callLow == $past(workingReg))
        else $error("call target wrong");
    a_ext_held_static: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
        cfgLoaded |=> $stable(extEn))
        else $error("extended enable changed");
    a_bank_select_use: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
        (live && isTest && bankBit && clkEn) |=> fileAddr[11:8] == $past(bankSelect))
        else $error("bank select unused");

endmodule
`default_nettype wire

// file: rtl/bsxd_defs.svh
// Constants for the bit-skip and extended-operation decoder
`ifndef BSXD_DEFS_SVH
`define BSXD_DEFS_SVH
`define BSXD_OP_SKIP_CLR    4'h b
`define BSXD_OP_SKIP_SET    4'h a
`define BSXD_OP_PTR_ADD     8'h e8
`define BSXD_OP_PTR_SUB     8'h e9
`define BSXD_OP_PUSH_LIT    8'h ea
`define BSXD_OP_STACK_MOVE  8'h eb
`define BSXD_OP_SECOND_WORD 4'h f
`define BSXD_OP_CALL_WORKING_REGISTER   16'h0014
`define BSXD_PTR_TWO        2'h3
`define BSXD_INDEX_LIMIT    8'h5f
`define BSXD_TIMER_ZERO     12'hfd6
`define BSXD_PORT_BASE      12'hf80
`define BSXD_PORT_LAST      12'hf84
`endif

// file: rtl/bsxd_pkg.sv
// Types for the bit-skip and extended-operation decoder
package bsxd_pkg;
    typedef enum logic [1:0] {
        BSXD_EXEC  = 2'b00,
        BSXD_FLUSH = 2'b01,
        BSXD_FLUSH2 = 2'b11
    } bsxd_state_t;
    typedef enum logic [3:0] {
        BSXD_NONE, BSXD_SKIP_CLR, BSXD_SKIP_SET, BSXD_PTR_ADD, BSXD_PTR_SUB,
        BSXD_ADD_RET, BSXD_SUB_RET, BSXD_CALL_W, BSXD_TO_FILE, BSXD_TO_STACK,
        BSXD_PUSH, BSXD_OPERAND
    } bsxd_op_t;
endpackage

// file: verification/bsxd_mem_model.sv
// Data file model that returns operand bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module bsxd_mem_model (
    input  wire logic [15:0] instrWord,
    input  wire logic        instrValid,
    output logic [7:0]       fileData
);
    // Cell value follows its address; idle cycles show the inverse so stale bytes never pass
    logic [7:0] cellValue;
    assign cellValue = instrWord[7:0] ^ 8'h96;
    assign fileData  = instrValid ? cellValue : ~cellValue;
endmodule
`default_nettype wire

// file: verification/bsxd_tb.sv
// Self-checking bench for the bit-skip and extended-operation decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_sys, rst, clkEn, extendedSetCfg, instrValid, prescalerOnTimer, rmwDestFile;
    logic [15:0] instrWord;
    logic [7:0]  fileData, pinData, workingReg, callLow, pushData;
    logic [3:0]  bankSelect;
    logic [11:0] pointerTwo, fileAddr, moveDst;
    logic        useIndexed, operandFromPins, clearPrescaler, skipTaken, nopCycle, pointerWrite;
    logic        pointerDecrement, returnReq, callReq, pushWrite, moveReq, moveToStack, illegalExt;
    logic [1:0]  pointerSel;
    logic [6:0]  pointerDelta, moveSrcOffset;
    int          failures, cmpCount;
    // ************
    // Instances
    // ************
    bsxd_mem_model bsxd_mem_model_i (.instrWord(instrWord), .instrValid(instrValid), .fileData(fileData));
    bsxd_decoder bsxd_decoder_i (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .extendedSetCfg(extendedSetCfg),
        .instrWord(instrWord), .instrValid(instrValid), .fileData(fileData), .pinData(pinData),
        .bankSelect(bankSelect), .workingReg(workingReg), .pointerTwo(pointerTwo),
        .prescalerOnTimer(prescalerOnTimer), .rmwDestFile(rmwDestFile), .fileAddr(fileAddr),
        .useIndexed(useIndexed), .operandFromPins(operandFromPins), .clearPrescaler(clearPrescaler),
        .skipTaken(skipTaken), .nopCycle(nopCycle), .pointerWrite(pointerWrite), .pointerSel(pointerSel),
        .pointerDelta(pointerDelta), .pointerDecrement(pointerDecrement), .returnReq(returnReq),
        .callReq(callReq), .callLow(callLow), .pushWrite(pushWrite), .pushData(pushData), .moveReq(moveReq),
        .moveToStack(moveToStack), .moveSrcOffset(moveSrcOffset), .moveDst(moveDst), .illegalExt(illegalExt));
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counted comparison; four-state match so unknowns fail
    task automatic chk(input string what, input logic [11:0] expVal, input logic [11:0] seen);
        cmpCount++;
        if (seen !== expVal) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, expVal, seen);
        end
    endtask
    // One word per cycle; outputs are read one edge later
    task automatic step(input logic [15:0] w);
        instrWord  = w;
        instrValid = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask
    // Config loads on the first edge after release, so one extra edge passes
    task automatic restart(input logic cfg);
        extendedSetCfg = cfg;
        instrValid     = 1'b0;
        rst            = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        @(posedge clk_sys);
        #1;
        chk("skipTaken", 0, skipTaken);
    endtask
    // Operand at 8'h60 reads 8'hf6: bits 0 and 3 clear, bit 1 set
    task automatic skip_tests();
        step(16'hb060);
        chk("skipTaken", 1, skipTaken);
        chk("fileAddr", 12'hf60, fileAddr);
        step(16'h0e12);
        chk("nopCycle", 1, nopCycle);
        step(16'hb260);
        chk("skipTaken", 0, skipTaken);
        chk("nopCycle", 0, nopCycle);
        step(16'ha260);
        chk("skipTaken", 1, skipTaken);
        step(16'ha660);
        chk("nopCycle", 1, nopCycle);
        step(16'ha660);
        chk("skipTaken", 0, skipTaken);
        step(16'hb060);
        step(16'hc123);
        chk("nopCycle", 1, nopCycle);
        step(16'hf456);
        chk("nopCycle", 1, nopCycle);
        step(16'h0000);
        chk("nopCycle", 0, nopCycle);
    endtask
    // Bank bit and indexed offset selection, tests not taken
    task automatic bank_tests();
        step(16'ha122);
        chk("fileAddr", 12'h522, fileAddr);
        step(16'ha070);
        chk("fileAddr", 12'hf70, fileAddr);
        chk("useIndexed", 0, useIndexed);
        step(16'ha020);
        chk("useIndexed", 1, useIndexed);
        chk("fileAddr", 12'h320, fileAddr);
    endtask
    // Pointer arithmetic, return variants and call through the working register
    task automatic pointer_tests();
        step(16'he84a);
        chk("pointerWrite", 1, pointerWrite);
        chk("pointerSel", 1, pointerSel);
        chk("pointerDelta", 10, pointerDelta);
        chk("pointerDecrement", 0, pointerDecrement);
        step(16'he94a);
        chk("pointerDecrement", 1, pointerDecrement);
        chk("nopCycle", 0, nopCycle);
        step(16'he8c5);
        chk("returnReq", 1, returnReq);
        chk("pointerSel", 3, pointerSel);
        step(16'h0000);
        chk("nopCycle", 1, nopCycle);
        step(16'he9c5);
        chk("returnReq", 1, returnReq);
        step(16'h0014);
        step(16'h0014);
        chk("callReq", 1, callReq);
        chk("callLow", 8'h3c, callLow);
        step(16'h0000);
        chk("nopCycle", 1, nopCycle);
    endtask
    // Stack moves, a lone second word and the literal push
    task automatic stack_tests();
        step(16'heb05);
        step(16'hf123);
        chk("moveReq", 1, moveReq);
        chk("moveToStack", 0, moveToStack);
        chk("moveSrcOffset", 5, moveSrcOffset);
        chk("moveDst", 12'h123, moveDst);
        chk("nopCycle", 0, nopCycle);
        step(16'heb85);
        step(16'hf007);
        chk("moveToStack", 1, moveToStack);
        chk("moveDst", 12'h007, moveDst);
        step(16'hf000);
        chk("nopCycle", 1, nopCycle);
        step(16'hea77);
        chk("pushWrite", 1, pushWrite);
        chk("pushData", 8'h77, pushData);
        chk("pointerDecrement", 1, pointerDecrement);
    endtask
    // Timer zero prescaler clear and port operand from pins
    task automatic rmw_tests();
        step(16'h2ad6);
        chk("clearPrescaler", 1, clearPrescaler);
        step(16'h2a80);
        chk("operandFromPins", 1, operandFromPins);
        chk("clearPrescaler", 0, clearPrescaler);
    endtask
    // Low clock enable must freeze every output, so a taken skip stays invisible
    task automatic freeze_tests();
        clkEn = 1'b0;
        step(16'hb060);
        chk("skipTaken", 0, skipTaken);
        chk("operandFromPins", 1, operandFromPins);
        step(16'hb060);
        chk("fileAddr", 12'hf80, fileAddr);
        instrValid = 1'b0;
        clkEn = 1'b1;
        @(posedge clk_sys);
        #1;
        chk("skipTaken", 0, skipTaken);
    endtask
    // Extended set off at load; a later change of the input must not matter
    task automatic disabled_tests();
        restart(1'b0);
        extendedSetCfg = 1'b1;
        step(16'hea77);
        chk("illegalExt", 1, illegalExt);
        chk("pushWrite", 0, pushWrite);
        step(16'ha020);
        chk("useIndexed", 0, useIndexed);
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        if (failures == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        failures = 0;
        cmpCount = 0;
        clkEn = 1'b1;
        instrWord = 16'h0000;
        pinData = 8'h5a;
        bankSelect = 4'h5;
        workingReg = 8'h3c;
        pointerTwo = 12'h300;
        prescalerOnTimer = 1'b1;
        rmwDestFile = 1'b1;
        restart(1'b1);
        skip_tests();
        bank_tests();
        pointer_tests();
        stack_tests();
        rmw_tests();
        freeze_tests();
        disabled_tests();
        wrap_up();
    end
endmodule
`default_nettype wire
